// ==== inc/mdea_defines.svh ====
/*
  Constants of the monitor display and energy accumulator block.
  Assumes a 100 MHz system clock and word-indexed register port.
*/
`ifndef MDEA_DEFINES_SVH
`define MDEA_DEFINES_SVH

// Register indexes
`define MDEA_ADR_MONSEL    3'h0
`define MDEA_ADR_CLEAR     3'h1
`define MDEA_ADR_SHIFT     3'h2
`define MDEA_ADR_COMM_KWH  3'h3
`define MDEA_ADR_COMM_CKWH 3'h4
`define MDEA_ADR_STATUS    3'h5

// Monitor select codes
`define MDEA_SEL_STEP      8'h00
`define MDEA_SEL_ENERGY    8'h19
`define MDEA_SEL_TERM      8'h37
`define MDEA_SEL_STOPFREQ  8'h64
`define MDEA_MONSEL_RST    8'h00

// Energy clear and digit shift codes
`define MDEA_CLR_DO        16'h0000
`define MDEA_CLR_RANGE10   16'h000a
`define MDEA_CLR_9999      16'h270f
`define MDEA_SHIFT_WRAP    16'h270f
`define MDEA_SHIFT_MAXN    16'h0004
`define MDEA_SHIFT_RST     16'h270f

// Limits, energy kept in 0.01 kWh
`define MDEA_ENERGY_MAX    24'h98967f
`define MDEA_PANEL_MAX     24'h00270f
`define MDEA_PU_MAX        24'h01869f
`define MDEA_COMM_MAX10    24'h00270f
`define MDEA_COMM_MAX      24'h00ffff

// Times in their own units
`define MDEA_CLK_HZ        64'h5f5e100
`define MDEA_ACC_PERIOD_H  64'h1
`define MDEA_HOLD_MS       64'h3e8
`define MDEA_BLINK_MS      64'hfa

`endif

// ==== inc/mdea_pkg.sv ====
/*
  Types of the monitor display and energy accumulator block.
  Assumes nothing beyond the defines header.
*/
package mdea_pkg;
  typedef enum logic [1:0] {
    MDEA_SLOT_FREQ  = 2'b00,
    MDEA_SLOT_CURR  = 2'b01,
    MDEA_SLOT_THIRD = 2'b10,
    MDEA_SLOT_FAULT = 2'b11
  } mdea_slot_type;
endpackage : mdea_pkg

// ==== core/mdea_core.sv ====
/*
  Panel monitor selection, stop/run frequency display, terminal LED view
  and cumulative output energy with per-channel formatting.
  Assumes all inputs synchronous to CLK and a single-cycle register port.
*/
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "mdea_defines.svh"

module mdea_core #(
  parameter logic [63:0] HOUR_CYCLES =
    `MDEA_ACC_PERIOD_H * 64'd3600 * `MDEA_CLK_HZ,
  parameter logic [31:0] HOLD_CYCLES =
    32'(`MDEA_HOLD_MS * (`MDEA_CLK_HZ / 64'd1000)),
  parameter logic [31:0] BLINK_CYCLES =
    32'(`MDEA_BLINK_MS * (`MDEA_CLK_HZ / 64'd1000))
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic [2:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  input  wire logic        SET_KEY,
  input  wire logic        RUNNING,
  input  wire logic        FAULT,
  input  wire logic        OUTPUT_INHIBIT,
  input  wire logic        AUTOTUNE,
  input  wire logic [15:0] OUT_FREQ,
  input  wire logic [15:0] SET_FREQ_LIM,
  input  wire logic [15:0] OUT_CURR,
  input  wire logic [15:0] OUT_VOLT,
  input  wire logic [15:0] FAULT_CODE,
  input  wire logic [15:0] SEL_VALUE,
  input  wire logic [15:0] TUNE_STATUS,
  input  wire logic [15:0] OUT_POWER,
  input  wire logic [7:0]  IN_TERM,
  input  wire logic [7:0]  OUT_TERM,
  output logic      [15:0] DISP_VALUE,
  output logic      [1:0]  DISP_DP,
  output logic             DISP_DASH,
  output logic             LED_HZ,
  output logic             LED_A,
  output logic             TERM_VIEW,
  output logic      [7:0]  SEG_UPPER,
  output logic      [7:0]  SEG_LOWER,
  output logic             SEG_CENTER,
  output logic      [1:0]  SLOT,
  output logic      [16:0] PU_VALUE,
  output logic      [1:0]  PU_DP,
  output logic             PU_DASH
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [23:0] shift_fn(input logic [23:0] v,
                                           input logic [2:0]  n);
    case (n)
      3'h0:    shift_fn = v;
      3'h1:    shift_fn = v / 24'd10;
      3'h2:    shift_fn = v / 24'd100;
      3'h3:    shift_fn = v / 24'd1000;
      3'h4:    shift_fn = v / 24'd10000;
      default: shift_fn = v;
    endcase
  endfunction : shift_fn

  // Returns {dash, dp, value}; lim is the top of the 0.01 range
  function automatic logic [19:0] fmt_fn(input logic [23:0] v,
                                         input logic [23:0] lim);
    logic [23:0] d10;
    logic [23:0] d100;
    d10  = v / 24'd10;
    d100 = v / 24'd100;
    if (v <= lim)
      fmt_fn = {1'b0, 2'h2, v[16:0]};
    else if (d10 <= lim)
      fmt_fn = {1'b0, 2'h1, d10[16:0]};
    else if (d100 <= lim)
      fmt_fn = {1'b0, 2'h0, d100[16:0]};
    else
      fmt_fn = {1'b1, 2'h0, 17'h00000};
  endfunction : fmt_fn

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]  monsel_reg;
  logic        range10_reg;
  logic [15:0] shift_reg;
  logic [23:0] acc_reg;
  logic [23:0] acc_next;
  logic [63:0] hour_cnt_reg;
  logic [31:0] key_cnt_reg;
  logic        key_d_reg;
  logic        held_reg;
  logic [31:0] blink_cnt_reg;
  logic        blink_reg;
  logic        fault_d_reg;
  logic [15:0] fault_freq_reg;
  mdea_pkg::mdea_slot_type slot_reg;
  mdea_pkg::mdea_slot_type first_reg;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  wire wr_monsel = WR && ADDR == `MDEA_ADR_MONSEL;
  wire wr_clear  = WR && ADDR == `MDEA_ADR_CLEAR;
  wire wr_shift  = WR && ADDR == `MDEA_ADR_SHIFT;
  wire clear_go  = wr_clear && WDATA == `MDEA_CLR_DO;
  wire shift_ok  = WDATA <= `MDEA_SHIFT_MAXN ||
                   WDATA == `MDEA_SHIFT_WRAP;
  wire wrap_mode = shift_reg == `MDEA_SHIFT_WRAP;
  wire [2:0] shift_n = wrap_mode ? 3'h0 : shift_reg[2:0];
  wire hour_tick = hour_cnt_reg == HOUR_CYCLES - 64'd1;

  wire sel_step   = monsel_reg == `MDEA_SEL_STEP;
  wire sel_stop   = monsel_reg == `MDEA_SEL_STOPFREQ;
  wire sel_term   = monsel_reg == `MDEA_SEL_TERM;
  wire sel_energy = monsel_reg == `MDEA_SEL_ENERGY;
  wire stopped    = !RUNNING || OUTPUT_INHIBIT;

  ////////////////////////////////////////////////////////////////////////
  // Energy

  // Clear first, then the hourly sample, so a tick is never lost
  wire [23:0] acc_base = clear_go ? 24'h000000 : acc_reg;
  wire [24:0] acc_sum  = {1'b0, acc_base} + {9'h000, OUT_POWER};
  wire        acc_ovf  = acc_sum > {1'b0, `MDEA_ENERGY_MAX};

  always_comb begin
    acc_next = acc_base;
    if (hour_tick) begin
      if (!acc_ovf)
        acc_next = acc_sum[23:0];
      else if (wrap_mode)
        acc_next = 24'h000000;
      else
        acc_next = `MDEA_ENERGY_MAX;
    end
  end

  wire [23:0] acc_shown = shift_fn(acc_reg, shift_n);
  wire [19:0] panel_fmt = fmt_fn(acc_shown, `MDEA_PANEL_MAX);
  wire [19:0] pu_fmt    = fmt_fn(acc_shown, `MDEA_PU_MAX);
  wire [23:0] comm_kwh  = acc_shown / 24'd100;
  wire [23:0] comm_lim  = range10_reg ? `MDEA_COMM_MAX10
                                      : `MDEA_COMM_MAX;
  wire [15:0] comm_w    = comm_kwh > comm_lim ? comm_lim[15:0]
                                              : comm_kwh[15:0];
  wire [15:0] comm_c    = acc_shown > `MDEA_COMM_MAX ? 16'hffff
                                                     : acc_shown[15:0];

  ////////////////////////////////////////////////////////////////////////
  // Display selection

  // Fault freezes the captured frequency; stop shows limited setpoint
  wire [15:0] freq_src = (FAULT && fault_d_reg) ? fault_freq_reg
                       : (sel_stop && stopped) ? SET_FREQ_LIM
                       : OUT_FREQ;
  wire [15:0] third_src = (sel_step || sel_stop) ? OUT_VOLT
                                                 : SEL_VALUE;
  wire is_third  = slot_reg == mdea_pkg::MDEA_SLOT_THIRD;
  wire show_term = is_third && sel_term && !AUTOTUNE;
  wire show_en   = is_third && sel_energy && !AUTOTUNE;

  logic [15:0] raw_val;
  always_comb begin
    case (slot_reg)
      mdea_pkg::MDEA_SLOT_FREQ:  raw_val = freq_src;
      mdea_pkg::MDEA_SLOT_CURR:  raw_val = OUT_CURR;
      mdea_pkg::MDEA_SLOT_THIRD: raw_val = third_src;
      mdea_pkg::MDEA_SLOT_FAULT: raw_val = FAULT_CODE;
      default:                   raw_val = OUT_FREQ;
    endcase
  end

  wire [15:0] disp_src = AUTOTUNE ? TUNE_STATUS : raw_val;
  wire        dash_src = show_en ? panel_fmt[19]
                       : disp_src > `MDEA_PANEL_MAX;
  wire [15:0] val_src  = dash_src ? 16'h0000
                       : show_en ? panel_fmt[15:0] : disp_src;
  wire        hz_src   = slot_reg == mdea_pkg::MDEA_SLOT_FREQ &&
                         !AUTOTUNE &&
                         (!(sel_stop && stopped) || blink_reg);
  wire        a_src    = slot_reg == mdea_pkg::MDEA_SLOT_CURR &&
                         !AUTOTUNE;

  ////////////////////////////////////////////////////////////////////////
  // Set key: short press steps, 1 s hold stores the first monitor

  wire key_rel  = key_d_reg && !SET_KEY;
  wire key_hold = SET_KEY && !held_reg &&
                  key_cnt_reg == HOLD_CYCLES - 32'd1;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      key_d_reg   <= 1'b0;
      key_cnt_reg <= 32'h00000000;
      held_reg    <= 1'b0;
      first_reg   <= mdea_pkg::MDEA_SLOT_FREQ;
      slot_reg    <= mdea_pkg::MDEA_SLOT_FREQ;
    end else begin
      key_d_reg   <= SET_KEY;
      key_cnt_reg <= SET_KEY && !held_reg ? key_cnt_reg + 32'd1
                                          : 32'h00000000;
      if (key_hold) begin
        held_reg  <= 1'b1;
        first_reg <= slot_reg;
      end else if (!SET_KEY) begin
        held_reg  <= 1'b0;
      end
      if (key_rel && !held_reg)
        slot_reg <= mdea_pkg::mdea_slot_type'(slot_reg + 2'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timers, fault capture, energy state

  always_ff @(posedge CLK) begin
    if (RESET) begin
      hour_cnt_reg   <= 64'h0;
      blink_cnt_reg  <= 32'h00000000;
      blink_reg      <= 1'b0;
      fault_d_reg    <= 1'b0;
      fault_freq_reg <= 16'h0000;
      acc_reg        <= 24'h000000;
    end else begin
      hour_cnt_reg <= hour_tick ? 64'h0 : hour_cnt_reg + 64'd1;
      if (blink_cnt_reg == BLINK_CYCLES - 32'd1) begin
        blink_cnt_reg <= 32'h00000000;
        blink_reg     <= !blink_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 32'd1;
      end
      fault_d_reg <= FAULT;
      if (FAULT && !fault_d_reg)
        fault_freq_reg <= OUT_FREQ;
      acc_reg <= acc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port

  always_ff @(posedge CLK) begin
    if (RESET) begin
      monsel_reg  <= `MDEA_MONSEL_RST;
      range10_reg <= 1'b0;
      shift_reg   <= `MDEA_SHIFT_RST;
    end else begin
      if (wr_monsel)
        monsel_reg <= WDATA[7:0];
      if (wr_clear && WDATA == `MDEA_CLR_RANGE10)
        range10_reg <= 1'b1;
      else if (wr_clear && WDATA == `MDEA_CLR_9999)
        range10_reg <= 1'b0;
      if (wr_shift && shift_ok)
        shift_reg <= WDATA;
    end
  end

  logic [15:0] rd_mux;
  always_comb begin
    case (ADDR)
      `MDEA_ADR_MONSEL:    rd_mux = {8'h00, monsel_reg};
      `MDEA_ADR_CLEAR:     rd_mux = range10_reg ? `MDEA_CLR_RANGE10
                                                : `MDEA_CLR_9999;
      `MDEA_ADR_SHIFT:     rd_mux = shift_reg;
      `MDEA_ADR_COMM_KWH:  rd_mux = comm_w;
      `MDEA_ADR_COMM_CKWH: rd_mux = comm_c;
      `MDEA_ADR_STATUS:    rd_mux = {10'h000, first_reg, slot_reg,
                                     FAULT, AUTOTUNE};
      default:             rd_mux = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Output flops

  always_ff @(posedge CLK) begin
    if (RESET) begin
      RDATA      <= 16'h0000;
      DISP_VALUE <= 16'h0000;
      DISP_DP    <= 2'h0;
      DISP_DASH  <= 1'b0;
      LED_HZ     <= 1'b0;
      LED_A      <= 1'b0;
      TERM_VIEW  <= 1'b0;
      SEG_UPPER  <= 8'h00;
      SEG_LOWER  <= 8'h00;
      SEG_CENTER <= 1'b0;
      SLOT       <= 2'h0;
      PU_VALUE   <= 17'h00000;
      PU_DP      <= 2'h0;
      PU_DASH    <= 1'b0;
    end else begin
      RDATA      <= RD ? rd_mux : 16'h0000;
      DISP_VALUE <= show_term ? 16'h0000 : val_src;
      DISP_DP    <= show_en ? panel_fmt[18:17] : 2'h0;
      DISP_DASH  <= !show_term && dash_src;
      LED_HZ     <= hz_src;
      LED_A      <= a_src;
      TERM_VIEW  <= show_term;
      SEG_UPPER  <= show_term ? IN_TERM : 8'h00;
      SEG_LOWER  <= show_term ? OUT_TERM : 8'h00;
      SEG_CENTER <= show_term;
      SLOT       <= slot_reg;
      PU_VALUE   <= pu_fmt[16:0];
      PU_DP      <= pu_fmt[18:17];
      PU_DASH    <= pu_fmt[19];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  key_step_a: assert property (
    key_rel && !held_reg && !key_hold |=>
      slot_reg == mdea_pkg::mdea_slot_type'($past(slot_reg) + 2'h1))
    else $error("slot did not step on short press");

  unit_led_a: assert property (!(LED_HZ && LED_A))
    else $error("two unit indicators lit");

  third_slot_a: assert property (
    is_third && sel_energy && !AUTOTUNE && !$past(RESET) |=>
      DISP_DASH || DISP_VALUE == $past(panel_fmt[15:0]))
    else $error("third slot not showing energy");

  first_store_a: assert property (
    key_hold |=> first_reg == $past(slot_reg) && held_reg)
    else $error("held key did not store first monitor");

  stop_freq_a: assert property (
    slot_reg == mdea_pkg::MDEA_SLOT_FREQ && sel_stop && stopped &&
    !FAULT && !AUTOTUNE && SET_FREQ_LIM <= 16'h270f |=>
      DISP_VALUE == $past(SET_FREQ_LIM))
    else $error("stop does not show set frequency");

  fault_hold_a: assert property (
    slot_reg == mdea_pkg::MDEA_SLOT_FREQ && FAULT && fault_d_reg &&
    !AUTOTUNE |=> DISP_DASH || DISP_VALUE == fault_freq_reg)
    else $error("fault frequency not held");

  tune_prio_a: assert property (
    AUTOTUNE |=> !TERM_VIEW && !LED_HZ &&
      (DISP_DASH || DISP_VALUE == $past(TUNE_STATUS)))
    else $error("tuning status lost priority");

  center_seg_a: assert property (
    TERM_VIEW |-> SEG_CENTER && SEG_UPPER == $past(IN_TERM))
    else $error("terminal view segments wrong");

  energy_idle_a: assert property (
    !hour_tick && !clear_go |=> $stable(acc_reg))
    else $error("energy changed between hourly ticks");

  energy_clamp_a: assert property (
    hour_tick && acc_ovf |=>
      acc_reg == ($past(wrap_mode) ? 24'h000000 : `MDEA_ENERGY_MAX))
    else $error("overflow not clamped or wrapped");

  energy_clear_a: assert property (
    clear_go && !hour_tick |=> acc_reg == 24'h000000)
    else $error("energy not cleared");

  dash_show_a: assert property (
    !AUTOTUNE && !is_third && raw_val > 16'h270f |=> DISP_DASH)
    else $error("large value not dashed");

  step_c:  cover property (key_rel && !held_reg);
  hold_c:  cover property (key_hold);
  tick_c:  cover property (hour_tick && acc_ovf && wrap_mode);
  term_c:  cover property (TERM_VIEW);

endmodule : mdea_core

// ==== testbench/mdea_panel_model.sv ====
/* Operator panel key and serial host model driving the register port.
   Assumes the core samples its inputs on the rising clk edge. */
`timescale 1ns/1ps
module mdea_panel_model (
  input  wire logic        clk,
  output logic      [2:0]  addr,
  output logic      [15:0] wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [15:0] rdata,
  output logic             set_key
);
  initial begin
    {addr, wdata, wr, rd, set_key} = '0;
  end

  // Write zero to the clear index empties the accumulator
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d; // Released data must not look valid
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg

  // Long hold stores the first monitor instead of stepping
  task automatic press(input int n);
    @(posedge clk);
    set_key <= 1'b1;
    repeat (n) @(posedge clk);
    set_key <= 1'b0;
  endtask : press
endmodule : mdea_panel_model

// ==== testbench/tb_top.sv ====
/* Self-checking bench of the monitor display and energy core.
   Assumes the panel model owns the key and the register port. */
`timescale 1ns/1ps
module tb_top;
  logic        clk, reset, running, fault, inhib, tune;
  logic [15:0] rdata, f_out, f_set, cur, volt, fcode, selv, tstat, pwr;
  logic [15:0] wdata, dv, d, fo;
  logic [2:0]  addr;
  logic        wr, rd, key, dash, hz, la, tv, ctr, pdash;
  logic [1:0]  dp, slot, pdp;
  logic [7:0]  it, ot, su, sl;
  logic [16:0] pv;
  int          err_count, checks, cyc, acc, sh, rng, p, t0, h0, h1;

  mdea_core #(.HOUR_CYCLES(64'd20), .HOLD_CYCLES(32'd5),
    .BLINK_CYCLES(32'd3)) mdea_core_inst (
    .CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .SET_KEY(key), .RUNNING(running),
    .FAULT(fault), .OUTPUT_INHIBIT(inhib), .AUTOTUNE(tune),
    .OUT_FREQ(f_out), .SET_FREQ_LIM(f_set), .OUT_CURR(cur),
    .OUT_VOLT(volt), .FAULT_CODE(fcode), .SEL_VALUE(selv),
    .TUNE_STATUS(tstat), .OUT_POWER(pwr), .IN_TERM(it), .OUT_TERM(ot),
    .DISP_VALUE(dv), .DISP_DP(dp), .DISP_DASH(dash), .LED_HZ(hz),
    .LED_A(la), .TERM_VIEW(tv), .SEG_UPPER(su), .SEG_LOWER(sl),
    .SEG_CENTER(ctr), .SLOT(slot), .PU_VALUE(pv), .PU_DP(pdp),
    .PU_DASH(pdash));
  mdea_panel_model mdea_panel_model_inst (.clk(clk), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .set_key(key));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      close_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", n, exp, got);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic nx(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : nx

  // Expected readouts from the bench's own energy total
  task automatic echk;
    int v, w, q;
    v = acc;
    if (sh <= 4) repeat (sh) v = v / 10;
    w = (v <= 9999) ? 2 : (v / 10 <= 9999) ? 1 : 0;
    q = (w == 2) ? v : (w == 1) ? v / 10 : v / 100;
    chk("disp_dash", dash, q > 9999);
    chk("disp_value", dv, (q > 9999) ? 0 : q);
    if (q <= 9999) chk("disp_dp", dp, w);
    w = (v <= 99999) ? 2 : (v / 10 <= 99999) ? 1 : 0;
    q = (w == 2) ? v : (w == 1) ? v / 10 : v / 100;
    chk("pu_dash", pdash, q > 99999);
    chk("pu_value", pv, (q > 99999) ? 0 : q);
    if (q <= 99999) chk("pu_dp", pdp, w);
    mdea_panel_model_inst.rd_reg(3'h3, d);
    q = v / 100;
    if (q > ((rng == 10) ? 9999 : 65535)) q = (rng == 10) ? 9999 : 65535;
    chk("comm_kwh", d, q);
    mdea_panel_model_inst.rd_reg(3'h4, d);
    chk("comm_ckwh", d, (v > 65535) ? 65535 : v);
  endtask : echk

  task automatic tick;
    p++;
    while (cyc < t0 + 20 * p) @(posedge clk);
    @(negedge clk);
    acc = acc + pwr;
    if (acc > 9999999) acc = (sh == 9999) ? 0 : 9999999;
    echk;
  endtask : tick

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {reset, running, fault, inhib, tune, err_count, checks, cyc} = '0;
    reset = 1'b1;
    pwr = '0;
    d = 16'($urandom(65596));
    // Panel values other than the fault code kept below the dash limit so digits can be compared
    f_out = 16'($urandom % 10000);
    f_set = 16'($urandom % 10000);
    cur   = 16'($urandom % 10000);
    volt  = 16'($urandom % 10000);
    selv  = 16'($urandom % 10000);
    tstat = 16'($urandom % 10000);
    {fcode, it, ot} = 32'($urandom);
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    nx(1);
    chk("slot", slot, 0);
    mdea_panel_model_inst.rd_reg(3'h1, d);
    chk("clear_param", d, 16'h270f);
    mdea_panel_model_inst.rd_reg(3'h2, d);
    chk("shift_param", d, 16'h270f);
    mdea_panel_model_inst.rd_reg(3'h6, d);
    chk("unmapped", d, 0);
    $display("test reset done");

    // Stop and run frequency views
    mdea_panel_model_inst.wr_reg(3'h0, 16'h0064);
    nx(2);
    chk("stop_freq", dv, f_set);
    {h0, h1} = '0;
    repeat (12) begin
      @(negedge clk);
      h0 += (hz === 1'b0);
      h1 += (hz === 1'b1);
    end
    chk("hz_blink", h0 > 0 && h1 > 0, 1);
    @(posedge clk) running <= 1'b1;
    nx(2);
    chk("run_freq", dv, f_out);
    chk("hz_steady", hz, 1);
    @(posedge clk) {inhib, f_set} <= {1'b1, 16'($urandom % 10000)};
    nx(2);
    chk("inhibit_freq", dv, f_set);
    fo = f_out;
    @(posedge clk) {inhib, fault} <= 2'b01;
    @(posedge clk) f_out <= f_out + 16'h0101;
    nx(2);
    chk("fault_freq", dv, fo);
    @(posedge clk) {fault, tune} <= 2'b01;
    nx(2);
    chk("tune_view", dv, tstat);
    @(posedge clk) {tune, running} <= 2'b00;
    $display("test frequency done");

    // Stepping, third slot, terminal view, first monitor
    mdea_panel_model_inst.wr_reg(3'h0, 16'h0000);
    @(posedge clk) cur <= 16'($urandom % 10000);
    mdea_panel_model_inst.press(1);
    nx(3);
    chk("slot", slot, 1);
    chk("curr", dv, cur);
    chk("led_a", la, 1);
    chk("led_hz", hz, 0);
    mdea_panel_model_inst.press(1);
    nx(3);
    chk("slot", slot, 2);
    chk("third_volt", dv, volt);
    mdea_panel_model_inst.wr_reg(3'h0, 16'h0007);
    nx(2);
    chk("third_sel", dv, selv);
    @(posedge clk) selv <= 16'h2710;
    nx(2);
    chk("dash", dash, 1);
    chk("dash_value", dv, 0);
    @(posedge clk) {it, ot} <= 16'($urandom);
    mdea_panel_model_inst.wr_reg(3'h0, 16'h0037);
    nx(2);
    chk("term_view", tv, 1);
    chk("seg_upper", su, it);
    chk("seg_lower", sl, ot);
    chk("seg_center", ctr, 1);
    mdea_panel_model_inst.press(7);
    nx(3);
    chk("slot_hold", slot, 2);
    mdea_panel_model_inst.rd_reg(3'h5, d);
    chk("first_mon", d[5:4], 2);
    mdea_panel_model_inst.press(1);
    nx(3);
    chk("slot", slot, 3);
    chk("fault_code", dv, (fcode > 16'h270f) ? 0 : fcode);
    chk("fault_dash", dash, fcode > 16'h270f);
    chk("fault_leds", {hz, la}, 0);
    repeat (3) mdea_panel_model_inst.press(1);
    nx(3);
    chk("slot", slot, 2);
    $display("test monitor done");

    // Energy: random power each hour, random shift, clamp then wrap
    mdea_panel_model_inst.wr_reg(3'h0, 16'h0019);
    mdea_panel_model_inst.wr_reg(3'h2, 16'h0000);
    mdea_panel_model_inst.wr_reg(3'h1, 16'h0000);
    {sh, acc, p} = '0;
    rng = 9999;
    @(posedge clk) pwr <= 16'he000 | 16'($urandom);
    for (int i = 0; i < 40 && pv === 17'h0; i++) @(negedge clk);
    t0 = cyc;
    acc = pwr;
    echk;
    repeat (200) begin
      @(posedge clk) pwr <= 16'he000 | 16'($urandom);
      sh = $urandom % 5;
      mdea_panel_model_inst.wr_reg(3'h2, 16'(sh));
      if (p == 100) begin
        rng = 10;
        mdea_panel_model_inst.wr_reg(3'h1, 16'h000a);
      end
      tick;
    end
    sh = 9999;
    mdea_panel_model_inst.wr_reg(3'h2, 16'h270f);
    tick;
    tick;
    // No more power, so later ticks cannot mask the clear
    @(posedge clk) pwr <= 16'h0000;
    mdea_panel_model_inst.wr_reg(3'h2, 16'h0005);
    mdea_panel_model_inst.rd_reg(3'h2, d);
    chk("shift_refused", d, 16'h270f);
    mdea_panel_model_inst.rd_reg(3'h1, d);
    chk("clear_param", d, 16'h000a);
    mdea_panel_model_inst.wr_reg(3'h1, 16'h270f);
    rng = 9999;
    mdea_panel_model_inst.rd_reg(3'h1, d);
    chk("clear_param", d, 16'h270f);
    mdea_panel_model_inst.wr_reg(3'h1, 16'h0000);
    acc = 0;
    nx(1);
    echk;
    $display("test energy done");
    close_out;
  end
endmodule : tb_top
